// ==== inc/timer_ctl_pkg.sv ====
package timer_ctl_pkg;

    // =========================================================
    // Register byte offsets on the APB
    // =========================================================
    localparam logic [7:0] OFS_CTRL1 = 8'h00;  // timer_control_one
    localparam logic [7:0] OFS_CTRL2 = 8'h04;  // timer_control_two
    localparam logic [7:0] OFS_FLAGS = 8'h08;  // timer_flags_register
    localparam logic [7:0] OFS_CAP1  = 8'h0c;  // capture_value one
    localparam logic [7:0] OFS_CAP2  = 8'h10;  // capture_value two
    localparam logic [7:0] OFS_CMP1  = 8'h14;  // compare_value_one
    localparam logic [7:0] OFS_CMP2  = 8'h18;  // compare_value_two
    localparam logic [7:0] OFS_COUNT = 8'h1c;  // Free-running counter

    // =========================================================
    // Field positions
    // =========================================================
    localparam int C1_CAP_IE   = 7;  // capture_irq_enable
    localparam int C1_CMP_IE   = 6;  // compare_irq_enable
    localparam int C1_OVF_IE   = 5;  // overflow_irq_enable
    localparam int C1_FORCE2   = 4;  // force_level_two
    localparam int C1_FORCE1   = 3;  // force_level_one
    localparam int C1_LVL2     = 2;  // output_level_two
    localparam int C1_EDGE1    = 1;  // capture_edge_one
    localparam int C1_LVL1     = 0;  // output_level_one
    localparam int C2_PIN1_EN  = 7;  // compare_pin_one_enable
    localparam int C2_PIN2_EN  = 6;  // compare_pin_two_enable
    localparam int C2_SPM      = 5;  // single_pulse_mode
    localparam int C2_PWM      = 4;  // Pulse-width mode
    localparam int C2_PRE_HI   = 3;  // prescaler_select high
    localparam int C2_PRE_LO   = 2;  // prescaler_select low
    localparam int C2_EDGE2    = 1;  // capture_edge_two
    localparam int C2_EXT_EDGE = 0;  // ext_clock_edge
    localparam int F_CAP1      = 7;  // capture_flag_one
    localparam int F_CMP1      = 6;  // compare_flag_one
    localparam int F_OVF       = 5;  // overflow_flag
    localparam int F_CAP2      = 4;  // capture_flag_two
    localparam int F_CMP2      = 3;  // compare_flag_two

    // =========================================================
    // Reset values and fixed loads
    // =========================================================
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [15:0] COUNT_RST   = 16'hfffc;
    localparam logic [15:0] COUNT_TOP   = 16'hffff;
    localparam logic [15:0] SPM_CAPTURE = 16'hfffd;
    localparam logic [15:0] CMP_RST     = 16'h8000;

    // =========================================================
    // Prescaler codes and terminal counts
    // =========================================================
    localparam logic [1:0] PRE_DIV4 = 2'b00;
    localparam logic [1:0] PRE_DIV2 = 2'b01;
    localparam logic [1:0] PRE_DIV8 = 2'b10;
    localparam logic [1:0] PRE_EXT  = 2'b11;
    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // =========================================================
    // Carriers
    // =========================================================
    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [7:0]  ctrl1;     // timer_control_one
        logic [7:0]  ctrl2;     // timer_control_two
        logic [7:0]  flags;     // Sticky event flags
        logic [7:0]  armed;     // Flags seen by a status read
        logic [15:0] count;     // Free-running counter
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic [15:0] cmp1;
        logic [15:0] cmp2;
        logic [2:0]  div;       // Prescaler
        logic [2:0]  sync_c1;   // Synchroniser chains
        logic [2:0]  sync_c2;
        logic [2:0]  sync_ext;
        logic [1:0]  halt_arm;  // Captures seen during halt
        logic        halt_d;
        logic        pin1;
        logic        pin2;
        logic        irq;
        logic        wake;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } state_t;

    localparam state_t STATE_RST = '{ctrl1: CTRL_RST, ctrl2: CTRL_RST,
                                     count: COUNT_RST, cmp1: CMP_RST,
                                     cmp2: CMP_RST, default: 0};

endpackage : timer_ctl_pkg

// ==== rtl/timer_ctl.sv ====
`timescale 1ns/1ns
// Function
// RULE_01: Wait mode: keep counting, interrupts wake
// RULE_02: Halt mode: counter and registers frozen; APB writes still change registers in halt, and a counter write reloads fffc
// RULE_03: Halt exit resumes; reset restarts count
// RULE_04: Halt capture edge arms capture at exit
// RULE_05: Capture flag one also from reload
// RULE_06: No compare flags in pulse-width mode
// RULE_07: One shared request, enable and mask gated
// RULE_08: Capture enable gates both capture flags
// RULE_09: Compare enable gates both compare flags
// RULE_10: Overflow enable gates overflow flag
// RULE_11: Force two copies level two to pin
// RULE_12: Force one copies level one to pin
// RULE_13: Level two on match two, modes pin
// RULE_14: Capture edge one selects polarity
// RULE_15: Level one driven on match one
// RULE_16: Pin one enable routes waveform only
// RULE_17: Pin two enable routes level only
// RULE_18: Single pulse started by capture edge
// RULE_19: Pulse-width repeating waveform on pin one
// RULE_20: Prescaler divide four, two, eight, external
// RULE_21: Capture edge two selects polarity
// RULE_22: External clock edge selects polarity
// RULE_23: Control registers reset to zero
// RULE_24: Status read then data access clears
// RULE_25: Counter reset value is fffc
// RULE_26: Synchronise inputs before edge detection
module timer_ctl
    import timer_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire apb_req_t    apb_in,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer pins
    input  wire logic        capture_input_one,
    input  wire logic        capture_input_two,
    input  wire logic        external_count_input,
    output logic             compare_pin_one,
    output logic             compare_pin_one_oe,
    output logic             compare_pin_two,
    output logic             compare_pin_two_oe,
    // CPU side
    input  wire logic        halt_mode,
    input  wire logic        wait_mode,
    input  wire logic        global_irq_mask,
    output logic             timer_irq,
    output logic             wake_from_wait
);

    // =========================================================
    // Helpers
    // =========================================================
    // Edge on a synchronised chain: [1] now, [2] one cycle older
    function automatic logic edge_hit(input logic [2:0] s, input logic rising);
        edge_hit = rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
    endfunction : edge_hit

    // Which flag a data register access clears
    function automatic logic [7:0] clear_map(input logic [7:0] a);
        clear_map = 8'h00;
        unique case (a)
            OFS_CAP1:  clear_map[F_CAP1] = 1'b1;
            OFS_CMP1:  clear_map[F_CMP1] = 1'b1;
            OFS_COUNT: clear_map[F_OVF]  = 1'b1;
            OFS_CAP2:  clear_map[F_CAP2] = 1'b1;
            OFS_CMP2:  clear_map[F_CMP2] = 1'b1;
            default:   clear_map = 8'h00;
        endcase
    endfunction : clear_map

    // =========================================================
    // State
    // =========================================================
    state_t      s_r;        // All state
    state_t      s_nxt;      // Its next value
    logic        acc;        // Completing APB access
    logic        wr_count;   // Counter reset by write
    logic        tick;       // Counter advance
    logic        ovf_evt;    // Rollover this cycle
    logic        e1;         // Qualified capture one edge
    logic        e2;         // Qualified capture two edge
    logic        ext_e;      // Qualified external edge
    logic        mode_pwm;   // Pulse-width mode wins
    logic        mode_spm;   // Single pulse only without it
    logic        halt_exit;  // Halt just left
    logic [15:0] cnt_inc;    // Counter plus one
    logic [7:0]  set_f;      // Flags raised this cycle
    logic [7:0]  clr_f;      // Flags cleared this cycle
    logic [7:0]  wdat;       // Written byte

    assign acc      = apb_in.psel & apb_in.penable & s_r.pready;
    assign wr_count = acc & apb_in.pwrite & (apb_in.paddr == OFS_COUNT);
    assign mode_pwm = s_r.ctrl2[C2_PWM];
    assign mode_spm = s_r.ctrl2[C2_SPM] & ~mode_pwm;
    assign halt_exit = s_r.halt_d & ~halt_mode;
    assign wdat     = apb_in.pwdata[7:0];
    assign cnt_inc  = s_r.count + 16'h0001;
    // Edges read stage two and three only, never stage one [RULE_26]
    assign e1    = edge_hit(s_r.sync_c1, s_r.ctrl1[C1_EDGE1]);     // [RULE_14]
    assign e2    = edge_hit(s_r.sync_c2, s_r.ctrl2[C2_EDGE2]);     // [RULE_21]
    assign ext_e = edge_hit(s_r.sync_ext, s_r.ctrl2[C2_EXT_EDGE]); // [RULE_22]

    // =========================================================
    // Next-state logic
    // =========================================================
    always_comb begin
        s_nxt   = s_r;
        tick    = 1'b0;
        ovf_evt = 1'b0;
        set_f   = 8'h00;
        clr_f   = 8'h00;

        // Input synchronisers, shifting every cycle [RULE_26]
        s_nxt.sync_c1  = {s_r.sync_c1[1:0], capture_input_one};
        s_nxt.sync_c2  = {s_r.sync_c2[1:0], capture_input_two};
        s_nxt.sync_ext = {s_r.sync_ext[1:0], external_count_input};
        s_nxt.halt_d   = halt_mode;

        // Prescaler; it also stops in halt [RULE_02]
        if (!halt_mode) begin
            unique case (s_r.ctrl2[C2_PRE_HI:C2_PRE_LO])
                PRE_DIV2: tick = (s_r.div >= DIV2_LAST);  // [RULE_20]
                PRE_DIV4: tick = (s_r.div >= DIV4_LAST);  // [RULE_20]
                PRE_DIV8: tick = (s_r.div >= DIV8_LAST);  // [RULE_20]
                PRE_EXT:  tick = ext_e;                   // [RULE_20]
            endcase
            // Free-runs in external mode,
            // so a switch may tick early
            s_nxt.div = tick ? 3'h0 : s_r.div + 3'h1;
        end

        // Counting goes on in wait; wait is not looked at here [RULE_01]
        if (tick) begin
            s_nxt.count = cnt_inc;
            if (s_r.count == COUNT_TOP) begin
                ovf_evt       = 1'b1;
                set_f[F_OVF]  = 1'b1;
            end
            if (mode_pwm) begin
                // Match two ends the period and reloads [RULE_19]
                if (cnt_inc == s_r.cmp1 && s_r.ctrl2[C2_PIN1_EN]) begin
                    s_nxt.pin1 = s_r.ctrl1[C1_LVL1];  // [RULE_16]
                end
                if (cnt_inc == s_r.cmp2) begin
                    s_nxt.count   = COUNT_RST;         // [RULE_19]
                    set_f[F_CAP1] = 1'b1;              // [RULE_05]
                    if (s_r.ctrl2[C2_PIN1_EN]) begin
                        s_nxt.pin1 = s_r.ctrl1[C1_LVL2];  // [RULE_13]
                    end
                end
                // No compare flags here at all [RULE_06]
            end else begin
                if (cnt_inc == s_r.cmp1) begin
                    // Single pulse keeps flag one quiet
                    set_f[F_CMP1] = ~mode_spm;
                    if (s_r.ctrl2[C2_PIN1_EN]) begin
                        s_nxt.pin1 = s_r.ctrl1[C1_LVL1];  // [RULE_15]
                    end
                end
                if (cnt_inc == s_r.cmp2) begin
                    set_f[F_CMP2] = 1'b1;
                    // Level two belongs to pin one in single pulse
                    if (s_r.ctrl2[C2_PIN2_EN] && !mode_spm) begin
                        s_nxt.pin2 = s_r.ctrl1[C1_LVL2];  // [RULE_13] [RULE_17]
                    end
                end
            end
        end

        // Capture inputs; during halt only arm [RULE_04]
        if (halt_mode) begin
            if (e1 && !mode_pwm && !mode_spm) begin
                s_nxt.halt_arm[0] = 1'b1;
            end
            if (e2) begin
                s_nxt.halt_arm[1] = 1'b1;
            end
        end else begin
            if (e1 && mode_spm) begin
                // Pulse start: reload, level two out [RULE_18]
                s_nxt.count   = COUNT_RST;
                s_nxt.cap1    = SPM_CAPTURE;
                set_f[F_CAP1] = 1'b1;
                if (s_r.ctrl2[C2_PIN1_EN]) begin
                    s_nxt.pin1 = s_r.ctrl1[C1_LVL2];  // [RULE_13]
                end
            end else if (e1 && !mode_pwm) begin
                s_nxt.cap1    = s_r.count;
                set_f[F_CAP1] = 1'b1;  // [RULE_05]
            end
            if (e2) begin
                s_nxt.cap2    = s_r.count;
                set_f[F_CAP2] = 1'b1;
            end
        end

        // A reset wake starts from fffc
        // Leaving halt: resume from held count, flush armed captures
        if (halt_exit) begin
            if (s_r.halt_arm[0]) begin
                s_nxt.cap1    = s_r.count;  // [RULE_03] [RULE_04]
                set_f[F_CAP1] = 1'b1;
            end
            if (s_r.halt_arm[1]) begin
                s_nxt.cap2    = s_r.count;  // [RULE_04]
                set_f[F_CAP2] = 1'b1;
            end
            s_nxt.halt_arm = 2'b00;
        end

        // Costs a wait state, eases timing
        // APB: pready one cycle after access phase starts
        s_nxt.pready  = apb_in.psel & apb_in.penable & ~s_r.pready;
        s_nxt.pslverr = 1'b0;
        if (apb_in.psel && apb_in.penable && !s_r.pready) begin
            s_nxt.prdata  = 32'h0000_0000;
            s_nxt.pslverr = 1'b0;
            unique case (apb_in.paddr)
                OFS_CTRL1: s_nxt.prdata[7:0]  = s_r.ctrl1;
                OFS_CTRL2: s_nxt.prdata[7:0]  = s_r.ctrl2;
                OFS_FLAGS: s_nxt.prdata[7:0]  = s_r.flags;
                OFS_CAP1:  s_nxt.prdata[15:0] = s_r.cap1;
                OFS_CAP2:  s_nxt.prdata[15:0] = s_r.cap2;
                OFS_CMP1:  s_nxt.prdata[15:0] = s_r.cmp1;
                OFS_CMP2:  s_nxt.prdata[15:0] = s_r.cmp2;
                OFS_COUNT: s_nxt.prdata[15:0] = s_r.count;
                default:   s_nxt.pslverr      = 1'b1;  // Unmapped
            endcase
        end

        if (acc) begin
            // Status read arms; data access clears armed flag [RULE_24]
            if (!apb_in.pwrite && apb_in.paddr == OFS_FLAGS) begin
                s_nxt.armed = s_r.flags;
            end
            clr_f       = clear_map(apb_in.paddr) & s_r.armed;  // [RULE_24]
            s_nxt.armed = s_nxt.armed & ~clear_map(apb_in.paddr);
            if (apb_in.pwrite) begin
                unique case (apb_in.paddr)
                    OFS_CTRL1: begin
                        s_nxt.ctrl1 = wdat;
                        // Forcing has no say in the special modes
                        if (!mode_pwm && !s_r.ctrl2[C2_SPM]) begin
                            if (wdat[C1_FORCE1] && s_r.ctrl2[C2_PIN1_EN]) begin
                                s_nxt.pin1 = wdat[C1_LVL1];  // [RULE_12]
                            end
                            if (wdat[C1_FORCE2] && s_r.ctrl2[C2_PIN2_EN]) begin
                                s_nxt.pin2 = wdat[C1_LVL2];  // [RULE_11]
                            end
                        end
                    end
                    OFS_CTRL2: s_nxt.ctrl2 = wdat;
                    OFS_CMP1:  s_nxt.cmp1  = apb_in.pwdata[15:0];
                    OFS_CMP2:  s_nxt.cmp2  = apb_in.pwdata[15:0];
                    OFS_COUNT: s_nxt.count = COUNT_RST;  // [RULE_25]
                    default:   s_nxt.count = s_nxt.count; // Read-only or unmapped
                endcase
            end
        end

        // No event lost to a late clear
        // Set wins over clear; low three bits stay zero
        s_nxt.flags = ((s_r.flags & ~clr_f) | set_f) & 8'hf8;

        // Single shared request [RULE_07]
        s_nxt.irq = ~global_irq_mask &
                    ((s_r.ctrl1[C1_CAP_IE] & (s_nxt.flags[F_CAP1] |
                                              s_nxt.flags[F_CAP2])) |  // [RULE_08]
                     (s_r.ctrl1[C1_CMP_IE] & (s_nxt.flags[F_CMP1] |
                                              s_nxt.flags[F_CMP2])) |  // [RULE_09]
                     (s_r.ctrl1[C1_OVF_IE] & s_nxt.flags[F_OVF]));     // [RULE_10]
        // Wake only from wait; halt is never ended here [RULE_01] [RULE_02]
        s_nxt.wake = s_nxt.irq & wait_mode;
    end

    // =========================================================
    // State register
    // =========================================================
    // Reset loads zero controls and counter fffc [RULE_23] [RULE_25] [RULE_03]
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =========================================================
    // Outputs, all straight from flops
    // =========================================================
    assign prdata             = s_r.prdata;
    assign pready             = s_r.pready;
    assign pslverr            = s_r.pslverr;
    assign compare_pin_one    = s_r.pin1;
    assign compare_pin_one_oe = s_r.ctrl2[C2_PIN1_EN];  // [RULE_16]
    assign compare_pin_two    = s_r.pin2;
    assign compare_pin_two_oe = s_r.ctrl2[C2_PIN2_EN];  // [RULE_17]
    assign timer_irq          = s_r.irq;
    assign wake_from_wait     = s_r.wake;

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Masking
    a_irq_mask_gate: assert property ( // [RULE_07]
        timer_irq |-> !$past(global_irq_mask))
        else $error("irq raised while masked");

    // Halt freeze
    a_halt_count_hold: assert property ( // [RULE_02]
        halt_mode && !wr_count |=> $stable(s_r.count))
        else $error("counter moved in halt");

    // No compares
    a_pwm_no_compare: assert property ( // [RULE_06]
        $rose(s_r.flags[F_CMP1]) || $rose(s_r.flags[F_CMP2]) |-> !$past(mode_pwm))
        else $error("compare flag in pulse-width mode");

    // Pulse start
    a_spm_pulse_start: assert property ( // [RULE_18]
        !halt_mode && mode_spm && e1 && !acc |=>
        s_r.count == COUNT_RST && s_r.cap1 == SPM_CAPTURE && s_r.flags[F_CAP1])
        else $error("single pulse start wrong");

    // Halt capture
    a_halt_exit_cap: assert property ( // [RULE_04]
        halt_exit && s_r.halt_arm[0] |=> s_r.flags[F_CAP1] && s_r.cap1 == $past(s_r.count))
        else $error("armed capture lost at halt exit");

    // Overflow
    a_overflow_flag: assert property ( // [RULE_10]
        ovf_evt ##1 (s_r.ctrl1[C1_OVF_IE] && !global_irq_mask) |=> timer_irq)
        else $error("overflow irq missing");

    // Wake
    a_wake_wait: assert property ( // [RULE_01]
        wake_from_wait |-> timer_irq && $past(wait_mode))
        else $error("wake without irq in wait");

    // Bus timing
    a_apb_ready: assert property (
        apb_in.psel && apb_in.penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    // Forcing
    a_force_pin_one: assert property ( // [RULE_12]
        acc && apb_in.pwrite && apb_in.paddr == OFS_CTRL1 && wdat[C1_FORCE1] &&
        s_r.ctrl2[C2_PIN1_EN] && !s_r.ctrl2[C2_SPM] && !mode_pwm && !tick && !e1
        |=> compare_pin_one == $past(wdat[C1_LVL1]))
        else $error("forced level not on pin one");

    // Reload
    a_count_write: assert property ( // [RULE_25]
        wr_count |=> s_r.count == COUNT_RST)
        else $error("counter write did not reload");

    c_pwm_reload: cover property (mode_pwm && $rose(s_r.flags[F_CAP1]));
    c_spm_start:  cover property (mode_spm && e1 && !halt_mode);
    c_halt_cap:   cover property (halt_exit && s_r.halt_arm != 2'b00);
    c_irq_wake:   cover property (wait_mode ##1 wake_from_wait);

endmodule : timer_ctl

// ==== test/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import timer_ctl_pkg::*;
    typedef struct {string nm; logic [15:0] exp; logic [15:0] msk; bit pin;} note_t;
    logic        mclk, sys_rst, halt_mode, wait_mode, global_irq_mask, ext_run, probe;
    logic        cap_one, cap_two, ext_clk, pready, pslverr, timer_irq, wake_from_wait;
    logic        compare_pin_one, compare_pin_one_oe, compare_pin_two, compare_pin_two_oe;
    apb_req_t    apb_in;
    logic [31:0] prdata, rv, base;
    logic [15:0] cur;
    logic [15:0] inc [5] = '{16'h10, 16'h20, 16'h8, 16'h4, 16'h0};  // Ticks in 64 cycles
    logic [7:0]  r8;
    logic [5:0]  obs;
    note_t       q[$];
    note_t       nt;
    int          n_errors, n_tests;
    timer_ctl u_timer_ctl (.mclk(mclk), .sys_rst(sys_rst), .apb_in(apb_in), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_input_one(cap_one),
        .capture_input_two(cap_two), .external_count_input(ext_clk),
        .compare_pin_one(compare_pin_one), .compare_pin_one_oe(compare_pin_one_oe),
        .compare_pin_two(compare_pin_two), .compare_pin_two_oe(compare_pin_two_oe),
        .halt_mode(halt_mode), .wait_mode(wait_mode), .global_irq_mask(global_irq_mask),
        .timer_irq(timer_irq), .wake_from_wait(wake_from_wait));
    timer_pins u_timer_pins (.mclk(mclk), .ext_run(ext_run), .cap_one(cap_one),
        .cap_two(cap_two), .ext_clk(ext_clk));
    assign obs = {timer_irq, wake_from_wait, compare_pin_one, compare_pin_one_oe,
                  compare_pin_two, compare_pin_two_oe};
    // =========================================
    // Clock, watchdog and verdict
    // =========================================
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        summarize();
    end
    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    // =========================================
    // Result watcher: oldest note against output
    // =========================================
    always @(posedge mclk) begin
        if (probe || (pready === 1'b1 && apb_in.pwrite === 1'b0)) begin
            nt = q.pop_front();
            cur = nt.pin ? {10'h0, obs} : prdata[15:0];
            n_tests++;
            if ((cur & nt.msk) !== nt.exp) begin
                n_errors++;
                $display("unexpected %s expected %h seen %h", nt.nm, nt.exp, cur & nt.msk);
            end
        end
        if (pready === 1'b1 && pslverr !== (apb_in.paddr > OFS_COUNT)) begin
            n_errors++;
            $display("unexpected pslverr expected %b seen %b", ~pslverr, pslverr);
        end
    end
    // =========================================
    // APB master, one transfer per call
    // =========================================
    task automatic apb(input logic [7:0] a, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        apb_in <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {16'h0, d}};
        @(posedge mclk);
        apb_in.penable <= 1'b1;
        // Bounded wait for the slave
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rv = prdata;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
        if (n >= 40) begin
            n_errors++;
            summarize();
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m,
                      input string s);
        q.push_back('{s, e, m, 1'b0});
        apb(a, 1'b0, 16'h0);
    endtask : rd
    task automatic pin_chk(input logic [5:0] e, input logic [5:0] m, input string s);
        q.push_back('{s, {10'h0, e}, {10'h0, m}, 1'b1});
        probe <= 1'b1;
        @(posedge mclk);
        probe <= 1'b0;
    endtask : pin_chk
    // =========================================
    // Main sequence
    // =========================================
    initial begin
        apb_in = '0;
        {sys_rst, halt_mode, global_irq_mask} = 3'h7;
        {wait_mode, ext_run, probe, n_errors, n_tests} = '0;
        r8 = 8'($urandom(32'hff46));
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        // Reset values, counter held by halt
        rd(OFS_CTRL1, 16'h0, 16'hffff, "ctrl1 reset");
        rd(OFS_CTRL2, 16'h0, 16'hffff, "ctrl2 reset");
        rd(OFS_COUNT, COUNT_RST, 16'hffff, "count reset");
        halt_mode <= 1'b0;
        $display("test reset done");
        // Random read-back, force bits left out
        r8 = 8'($urandom()) & 8'he7;
        apb(OFS_CTRL1, 1'b1, {8'h0, r8});
        rd(OFS_CTRL1, {8'h0, r8}, 16'hffff, "ctrl1 rw");
        apb(OFS_CTRL1, 1'b1, 16'h0);
        rd(8'h20, 16'h0, 16'hffff, "unmapped");
        $display("test access done");
        // Each clock source over 64 cycles, then halt
        ext_run <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(OFS_CTRL2, 1'b1, {12'h0, (i == 4) ? 2'b01 : 2'(i), 2'b01});
            halt_mode <= (i == 4);
            rd(OFS_COUNT, 16'h0, 16'h0, "base");
            base = rv;
            repeat (60) @(posedge mclk);
            rd(OFS_COUNT, base[15:0] + inc[i], 16'hffff, "ticks");
        end
        halt_mode <= 1'b0;
        ext_run <= 1'b0;
        $display("test prescaler done");
        // Overflow request, masked then unmasked in wait
        apb(OFS_CTRL2, 1'b1, 16'h0004);
        apb(OFS_CTRL1, 1'b1, 16'h0020);
        apb(OFS_COUNT, 1'b1, 16'h0);
        repeat (20) @(posedge mclk);
        pin_chk(6'h00, 6'h30, "irq masked");
        global_irq_mask <= 1'b0;
        wait_mode <= 1'b1;
        repeat (3) @(posedge mclk);
        pin_chk(6'h30, 6'h30, "irq wake");
        rd(OFS_FLAGS, 16'h0020, 16'h0020, "ovf flag");
        rd(OFS_COUNT, 16'h0, 16'h0, "ovf clear");
        repeat (3) @(posedge mclk);
        pin_chk(6'h00, 6'h30, "irq cleared");
        wait_mode <= 1'b0;
        $display("test irq done");
        // Forced levels onto both pins
        apb(OFS_CTRL2, 1'b1, 16'h00c4);
        apb(OFS_CTRL1, 1'b1, 16'h001d);
        repeat (2) @(posedge mclk);
        pin_chk(6'h0f, 6'h3f, "force on");
        apb(OFS_CTRL2, 1'b1, 16'h0044);
        apb(OFS_CTRL1, 1'b1, 16'h0010);
        repeat (2) @(posedge mclk);
        pin_chk(6'h01, 6'h37, "force low");
        $display("test force done");
        // Capture two armed in halt, rising only
        apb(OFS_CTRL2, 1'b1, 16'h0006);
        halt_mode <= 1'b1;
        u_timer_pins.set_two(1'b1);
        repeat (8) @(posedge mclk);
        rd(OFS_COUNT, 16'h0, 16'h0, "base");
        base = rv;
        halt_mode <= 1'b0;
        rd(OFS_FLAGS, 16'h0010, 16'h0010, "cap2 rise");
        rd(OFS_CAP2, base[15:0], 16'hffff, "cap2 halt");
        u_timer_pins.set_two(1'b0);
        repeat (8) @(posedge mclk);
        rd(OFS_FLAGS, 16'h0, 16'h0010, "cap2 fall");
        $display("test capture done");
        summarize();
    end
endmodule : testbench

// ==== test/timer_pins.sv ====
`timescale 1ns/1ns
module timer_pins (
    // Clock and enable
    input  wire logic mclk,
    input  wire logic ext_run,
    // Pins toward the timer
    output logic      cap_one,
    output logic      cap_two,
    output logic      ext_clk
);
    logic [2:0] ph_r;  // Half-period count
    initial begin
        cap_one = 1'b0;
        cap_two = 1'b0;
        ext_clk = 1'b0;
        ph_r    = 3'h0;
    end
    // =========================================
    // External count clock, period 16 cycles
    // =========================================
    always @(posedge mclk) begin
        ph_r <= ph_r + 3'h1;
        // Held still while not in use
        if (ext_run && ph_r == 3'h7) begin
            ext_clk <= ~ext_clk;
        end
    end
    // Move capture two to a level just after an edge
    task automatic set_two(input logic lvl);
        @(posedge mclk);
        cap_two <= lvl;
    endtask : set_two
endmodule : timer_pins
